//--- rtl/hwr_pkg.sv
// Package for the halt and wake recovery controller.
// Assumes a single 125 MHz clock and an APB register port with 32-bit data.
package hwr_pkg;

	// ==========================================================
	// Clock and timing
	localparam int unsigned CLOCK_PERIOD_PS      = 8000;
	// The core clock period that the delay is counted in, in picoseconds.
	localparam int unsigned CORE_PERIOD_PS       = 100000;
	localparam int unsigned RESET_DELAY_PERIODS  = 128;
	localparam int unsigned OSC_STARTUP_PERIODS  = 5;
	localparam int unsigned WAKE_PULSE_MIN_NS    = 25;
	localparam int unsigned WAKE_PULSE_CYCLES    =
		((WAKE_PULSE_MIN_NS * 1000) / CLOCK_PERIOD_PS) > 0 ?
		((WAKE_PULSE_MIN_NS * 1000) / CLOCK_PERIOD_PS) : 1;
	localparam int unsigned RESET_DELAY_CYCLES   =
		((RESET_DELAY_PERIODS + OSC_STARTUP_PERIODS) * CORE_PERIOD_PS + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;

	// ==========================================================
	// Core interface constants
	localparam logic [7:0]  HALT_OPCODE          = 8'h6F;
	localparam logic [15:0] RESTART_VECTOR       = 16'h0020;

	// ==========================================================
	// Register map
	localparam logic [11:0] CTRL_OFFSET          = 12'h000;
	localparam logic [11:0] STATUS_OFFSET        = 12'h004;
	localparam int unsigned CTRL_WAKE_DIR_BIT    = 0;
	localparam int unsigned CTRL_WAKE_FUNC_BIT   = 1;
	localparam int unsigned STATUS_FLAG_BIT      = 0;
	localparam int unsigned STATUS_HALTED_BIT    = 1;
	localparam int unsigned STATUS_WAITING_BIT   = 2;
	localparam logic [1:0]  CTRL_RESET           = 2'h0;

	typedef enum logic [1:0] {
		HWR_RUN,
		HWR_HALT,
		HWR_WAIT
	} hwr_state_t;

endpackage : hwr_pkg

//--- rtl/hwr_delay_counter.sv
// Down counter that times the restart delay after a wake.
// Assumes a start pulse while idle; done pulses once when the count ends.
module hwr_delay_counter #(
	parameter int unsigned CYCLES = 1024
) (
	// Clock and reset
	input  wire logic clock,
	input  wire logic rstn,
	// Control
	input  wire logic start,
	output logic      busy,
	output logic      done
);

	localparam int unsigned W = $clog2(CYCLES + 1);
	localparam logic [W-1:0] LOAD = W'(CYCLES);

	logic [W-1:0] count_r;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			count_r <= '0;
			done    <= 1'b0;
		end else begin
			done <= 1'b0;
			if (start && count_r == '0) begin
				count_r <= LOAD;
			end else if (count_r != '0) begin
				count_r <= count_r - W'(1);
				done    <= (count_r == W'(1));
			end
		end
	end

	assign busy = (count_r != '0);

endmodule : hwr_delay_counter

//--- rtl/hwr_halt_recovery.sv
// Halt and wake recovery controller for a small 8-bit core.
// Assumes the core presents each executed opcode with a one-cycle strobe,
// and that the wake pin is already synchronous to the clock.
//
// Operation
// R1 - The halt opcode switches off the oscillator and the system clock.
// R2 - The halt opcode alone enters halt; no preceding no-op is needed.
// R3 - Halt ends only on power-up reset or the wake recovery source.
// R4 - Any reset that ends halt restarts execution at vector 0020h.
// R5 - A reset that ends halt sets the halt-status flag.
// R6 - Reading the halt-status flag does not change it.
// R7 - Software must clear the halt-status flag after recovery.
// R8 - A low level on port B bit 0 triggers the wake recovery.
// R9 - Software must set the wake pin as input with its wake function before halt.
// R10 - The wake source holds the pin low for at least 25 ns.
// R11 - After a pin wake, execution waits 128 core periods plus oscillator start-up.
// R12 - A pin wake leaves the control registers at their values.
// R13 - The flag clears on a software write of zero and otherwise holds.
//
// Local design decisions: the register offsets and register access over APB.
module hwr_halt_recovery #(
	parameter int unsigned DELAY_CYCLES = hwr_pkg::RESET_DELAY_CYCLES,
	parameter int unsigned PULSE_CYCLES = hwr_pkg::WAKE_PULSE_CYCLES
) (
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        rstn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Core
	input  wire logic        opcodeValid,
	input  wire logic [7:0]  opcode,
	output logic             oscEnable,
	output logic             sysClockEnable,
	output logic             coreHold,
	output logic             restartPulse,
	output logic      [15:0] restartVector,
	// Wake pin
	input  wire logic        portBBit0WakePin
);

	// ==========================================================
	// Registers
	hwr_pkg::hwr_state_t state_r;
	hwr_pkg::hwr_state_t state_nxt;
	logic [1:0]          ctrl_r;
	logic                haltFlag_r;
	logic                flagSet;
	logic                delayBusy;
	logic                delayDone;
	logic                wakeArmed;
	logic [7:0]          lowCount_r;
	logic                wakeSeen;
	logic                restartNow;
	logic                flagClear;
	logic                apbSetup;
	logic                apbRead;
	logic                isHalted;
	logic                haltOp;

	function automatic logic hitReg(input logic [11:0] addr, input logic [11:0] offs);
		hitReg = (addr == offs);
	endfunction : hitReg

	logic apbAccess;
	logic apbWrite;
	assign apbAccess = psel && penable;
	assign apbWrite  = apbAccess && pwrite;

	// The wake path only works when software has made the pin an input with its wake function.
	assign wakeArmed = ctrl_r[hwr_pkg::CTRL_WAKE_DIR_BIT] && ctrl_r[hwr_pkg::CTRL_WAKE_FUNC_BIT]; // R9

	// ==========================================================
	// Wake pulse qualification
	// A low shorter than the minimum width is ignored, which filters glitches.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			lowCount_r <= 8'h00;
		end else if (state_r == hwr_pkg::HWR_HALT && wakeArmed && !portBBit0WakePin) begin // R8
			if (lowCount_r != 8'(PULSE_CYCLES)) begin
				lowCount_r <= lowCount_r + 8'h01;
			end
		end else begin
			lowCount_r <= 8'h00;
		end
	end

	assign wakeSeen = (lowCount_r == 8'(PULSE_CYCLES)); // R10

	// ==========================================================
	// Delay counter
	hwr_delay_counter #(
		.CYCLES (DELAY_CYCLES)
	) u_delay (
		.clock (clock),
		.rstn  (rstn),
		.start (state_r == hwr_pkg::HWR_HALT && wakeSeen),
		.busy  (delayBusy),
		.done  (delayDone)
	);

	// ==========================================================
	// State machine
	// Only the halt opcode itself is decoded; any opcode before it is irrelevant.
	function automatic logic isHaltOpcode(input logic valid, input logic [7:0] op);
		isHaltOpcode = valid && (op == hwr_pkg::HALT_OPCODE);
	endfunction : isHaltOpcode

	assign haltOp     = isHaltOpcode(opcodeValid, opcode); // R2
	assign isHalted   = (state_r == hwr_pkg::HWR_HALT);
	assign restartNow = (state_r == hwr_pkg::HWR_WAIT) && delayDone; // R4

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			hwr_pkg::HWR_RUN: begin
				if (haltOp) begin // R2
					state_nxt = hwr_pkg::HWR_HALT;
				end
			end
			hwr_pkg::HWR_HALT: begin
				if (wakeSeen) begin // R3
					state_nxt = hwr_pkg::HWR_WAIT;
				end
			end
			hwr_pkg::HWR_WAIT: begin
				if (delayDone) begin // R11
					state_nxt = hwr_pkg::HWR_RUN;
				end
			end
			default: begin
				state_nxt = hwr_pkg::HWR_RUN;
			end
		endcase
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			state_r <= hwr_pkg::HWR_RUN;
		end else begin
			state_r <= state_nxt;
		end
	end

	// ==========================================================
	// Oscillator and clock gates
	// The oscillator restarts with the wake, so its start-up runs inside the delay.
	// Both gates follow the next state, so they move on the edge that changes state.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			oscEnable <= 1'b1;
		end else begin
			oscEnable <= (state_nxt != hwr_pkg::HWR_HALT); // R1
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			sysClockEnable <= 1'b1;
		end else begin
			sysClockEnable <= (state_nxt == hwr_pkg::HWR_RUN); // R1
		end
	end

	// ==========================================================
	// Core hold and restart
	// The core stays held through the whole delay, so it never fetches before the clock is stable.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			coreHold <= 1'b0;
		end else begin
			coreHold <= (state_nxt != hwr_pkg::HWR_RUN); // R11
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			restartPulse <= 1'b0;
		end else begin
			restartPulse <= restartNow; // R4
		end
	end

	// The vector is constant, yet it sits in a flop so the port comes straight from a register.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			restartVector <= hwr_pkg::RESTART_VECTOR;
		end else begin
			restartVector <= hwr_pkg::RESTART_VECTOR; // R4
		end
	end

	// ==========================================================
	// Control register
	// Only the power-up reset and software writes change it; the wake path never touches it.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			ctrl_r <= hwr_pkg::CTRL_RESET;
		end else if (apbWrite && hitReg(paddr, hwr_pkg::CTRL_OFFSET)) begin // R12
			ctrl_r <= pwdata[1:0];
		end
	end

	// ==========================================================
	// Halt-status flag
	// Power-up counts as a reset that ends halt, so the flag starts set.
	// A recovery in the same cycle as a software clear wins, so no wake is ever lost.
	assign flagSet   = restartNow; // R5
	assign flagClear = apbWrite && hitReg(paddr, hwr_pkg::STATUS_OFFSET) &&
		!pwdata[hwr_pkg::STATUS_FLAG_BIT];

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			haltFlag_r <= 1'b1; // R5
		end else if (flagSet) begin
			haltFlag_r <= 1'b1; // R5
		end else if (flagClear) begin
			haltFlag_r <= 1'b0; // R13 R7
		end
	end

	// ==========================================================
	// APB decode helpers
	// Both registers answer with no wait state, so the decode stays purely combinational.
	function automatic logic isMapped(input logic [11:0] addr);
		isMapped = hitReg(addr, hwr_pkg::CTRL_OFFSET) || hitReg(addr, hwr_pkg::STATUS_OFFSET);
	endfunction : isMapped

	function automatic logic [31:0] ctrlWord(input logic [1:0] ctrl);
		ctrlWord                              = 32'h0000_0000;
		ctrlWord[hwr_pkg::CTRL_WAKE_DIR_BIT]  = ctrl[hwr_pkg::CTRL_WAKE_DIR_BIT];
		ctrlWord[hwr_pkg::CTRL_WAKE_FUNC_BIT] = ctrl[hwr_pkg::CTRL_WAKE_FUNC_BIT];
	endfunction : ctrlWord

	function automatic logic [31:0] statusWord(input logic flag, input logic halted, input logic waiting);
		statusWord                              = 32'h0000_0000;
		statusWord[hwr_pkg::STATUS_FLAG_BIT]    = flag;
		statusWord[hwr_pkg::STATUS_HALTED_BIT]  = halted;
		statusWord[hwr_pkg::STATUS_WAITING_BIT] = waiting;
	endfunction : statusWord

	assign apbSetup = psel && !penable;
	assign apbRead  = apbSetup && !pwrite;

	// ==========================================================
	// APB handshake
	// Ready follows every setup phase by one cycle, so each transfer takes two cycles.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			pready <= 1'b0;
		end else begin
			pready <= apbSetup;
		end
	end

	// An unmapped address answers with an error; a write there changes nothing.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			pslverr <= 1'b0;
		end else begin
			pslverr <= apbSetup && !isMapped(paddr);
		end
	end

	// ==========================================================
	// APB read data
	// Reads have no side effect on any state, so software may poll the flag freely.
	// The word is captured in the setup cycle and stands through the access cycle.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			prdata <= 32'h0000_0000;
		end else if (apbRead && hitReg(paddr, hwr_pkg::CTRL_OFFSET)) begin
			prdata <= ctrlWord(ctrl_r);
		end else if (apbRead && hitReg(paddr, hwr_pkg::STATUS_OFFSET)) begin
			prdata <= statusWord(haltFlag_r, isHalted, delayBusy); // R6
		end else begin
			prdata <= 32'h0000_0000;
		end
	end

endmodule : hwr_halt_recovery

//--- verification/hwr_wake_src.sv
// Wake pin source: pulls the pin low for a requested count of cycles.
// Assumes fire is a one-cycle strobe from the bench.
module hwr_wake_src (
	// Clock
	input  wire logic       clock,
	// Request
	input  wire logic       fire,
	input  wire logic [3:0] width,
	// Pin, pulled up while released
	output logic            wakePin
);
	logic [3:0] left_r = 4'h0;
	always_ff @(posedge clock) begin
		left_r <= fire ? width : (left_r != 4'h0 ? left_r - 4'h1 : 4'h0);
	end
	assign wakePin = (left_r == 4'h0);
endmodule : hwr_wake_src

//--- verification/hwr_halt_recovery_chk.sv
// Checker for the halt and wake recovery controller.
// Assumes it is bound to hwr_halt_recovery and sees only its ports.
module hwr_halt_recovery_chk #(
	parameter int DELAY_CYCLES = 10
) (
	// Clock and reset
	input wire logic        clock,
	input wire logic        rstn,
	// APB
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pready,
	input wire logic        pslverr,
	// Core and pin
	input wire logic        opcodeValid,
	input wire logic [7:0]  opcode,
	input wire logic        oscEnable,
	input wire logic        sysClockEnable,
	input wire logic        coreHold,
	input wire logic        restartPulse,
	input wire logic [15:0] restartVector,
	input wire logic        portBBit0WakePin
);
	// The restart edge may fall one cycle either side of the nominal count.
	localparam int DLO = DELAY_CYCLES - 1;
	localparam int DHI = DELAY_CYCLES + 1;
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);
	sequence haltOp;
		opcodeValid && opcode == 8'h6F && sysClockEnable;
	endsequence
	sequence wakeUp;
		$rose(oscEnable);
	endsequence
	halt_entry_a: assert property (haltOp |=> !oscEnable && !sysClockEnable && coreHold)
		else $error("halt not entered");
	halt_hold_a: assert property (!oscEnable && portBBit0WakePin |=> !oscEnable)
		else $error("left halt without wake");
	wake_cause_a: assert property (wakeUp |-> !$past(portBBit0WakePin))
		else $error("wake without low pin");
	restart_delay_a: assert property (wakeUp |-> !restartPulse ##[DLO:DHI] restartPulse)
		else $error("restart delay wrong");
	restart_run_a: assert property (restartPulse |-> ##[0:1] (sysClockEnable && !coreHold))
		else $error("no run after restart");
	vector_fixed_a: assert property (restartVector == 16'h0020)
		else $error("restart vector wrong");
	clock_off_a: assert property (!oscEnable |-> !sysClockEnable && coreHold)
		else $error("clock runs in halt");
	apb_answer_a: assert property (psel && penable |-> pready && $past(psel))
		else $error("no APB answer");
	err_pair_a: assert property (pslverr |-> pready)
		else $error("error without ready");
endmodule : hwr_halt_recovery_chk
bind hwr_halt_recovery hwr_halt_recovery_chk #(.DELAY_CYCLES(DELAY_CYCLES)) chk (.*);

//--- verification/hwr_halt_recovery_test.sv
// Testbench for the halt and wake recovery controller.
// Assumes a short restart delay of ten cycles and the wake pin source model.
module hwr_halt_recovery_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic opcodeValid = 1'b0, fire = 1'b0, pready, pslverr, oscEnable, sysClockEnable;
	logic coreHold, restartPulse, wakePin;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata, q;
	logic [15:0] restartVector;
	logic [7:0] opcode = 8'h00;
	logic [3:0] width = 4'h0;
	logic e;
	int errors = 0, samplesChecked = 0;
	hwr_halt_recovery #(.DELAY_CYCLES(10)) dut (.clock(clock), .rstn(rstn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .opcodeValid(opcodeValid), .opcode(opcode),
		.oscEnable(oscEnable), .sysClockEnable(sysClockEnable), .coreHold(coreHold),
		.restartPulse(restartPulse), .restartVector(restartVector), .portBBit0WakePin(wakePin));
	hwr_wake_src src (.clock(clock), .fire(fire), .width(width), .wakePin(wakePin));
	initial begin
		forever #4 clock = ~clock;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samplesChecked++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do @(posedge clock); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask : apb
	task automatic exec(input logic [7:0] op);
		opcodeValid <= 1'b1;
		opcode <= op;
		@(posedge clock);
		opcodeValid <= 1'b0;
		@(negedge clock);
	endtask : exec
	task automatic t_regs;
		apb(1'b0, 12'h004, 32'h0000_0000);
		chk(q, 32'h0000_0001);
		apb(1'b0, 12'h004, 32'h0000_0000);
		chk(q, 32'h0000_0001);
		apb(1'b1, 12'h004, 32'h0000_0001);
		apb(1'b0, 12'h004, 32'h0000_0000);
		chk(q, 32'h0000_0001);
		apb(1'b1, 12'h004, 32'h0000_0000);
		apb(1'b0, 12'h004, 32'h0000_0000);
		chk(q, 32'h0000_0000);
		apb(1'b0, 12'h008, 32'h0000_0000);
		chk({e, q[30:0]}, 32'h8000_0000);
		$display("test regs done");
	endtask : t_regs
	task automatic t_halt_wake;
		exec(8'h00);
		chk(sysClockEnable, 1'b1);
		@(posedge clock);
		exec(8'h6F);
		chk({oscEnable, sysClockEnable, coreHold}, 3'b001);
		@(posedge clock);
		fire <= 1'b1;
		width <= 4'h4;
		@(posedge clock);
		fire <= 1'b0;
		repeat (12) @(posedge clock);
		chk(oscEnable, 1'b0);
		apb(1'b0, 12'h004, 32'h0000_0000);
		chk(q, 32'h0000_0002);
		apb(1'b1, 12'h000, 32'h0000_0003);
		fire <= 1'b1;
		@(posedge clock);
		fire <= 1'b0;
		do @(negedge clock); while (restartPulse !== 1'b1);
		chk(restartVector, 16'h0020);
		@(posedge clock);
		apb(1'b0, 12'h004, 32'h0000_0000);
		chk(q[0], 1'b1);
		apb(1'b0, 12'h000, 32'h0000_0000);
		chk(q, 32'h0000_0003);
		$display("test halt wake done");
	endtask : t_halt_wake
	task automatic finish_test;
		$display("checked %0d mismatches %0d", samplesChecked, errors);
		if (errors == 0 && samplesChecked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : finish_test
	initial begin
		repeat (3000) @(posedge clock);
		errors++;
		finish_test();
	end
	initial begin
		repeat (8) @(posedge clock);
		rstn <= 1'b1;
		@(posedge clock);
		t_regs();
		t_halt_wake();
		finish_test();
	end
endmodule : hwr_halt_recovery_test
